// ===== inc/aps_defines.vh
// Overview of operation
// - Servo-on status follows drive power state.
// - Warning word keeps most recent warning code.
// - Alarm word keeps most recent alarm code.
// - Response word shows running command code.
// - Executing flag high during abort processing.
// - Hold-completed once paused axis fully stopped.
// - Error sets flag, decelerates; next command clears.
// - Execution-completed stays low for target positioning.
// - Distribution-done high when distribution finished.
// - In-position needs distribution done and width.
// - Proximity follows done, or difference below width.
// - Latch adds extra travel from latch point.
// - Speed changes live; override up to 327.67%.
// - Target updates accepted until latch detected.
// - Latch zone only when drive supports it.
// - Code 2 starts; same-scan settings used.
// - Execution-completed set after latch travel stop.
// - Function word selects latch source 2..5.
// - Latches outside enabled zone are ignored.
// - Pause decelerates to stop; clear resumes travel.
// - Code 1 starts; code 0 cancels.
`ifndef APS_DEFINES_VH
`define APS_DEFINES_VH

// ****************************************************************
// Scan timing
// ****************************************************************
`define APS_CLK_NS 10
`define APS_SCAN_NS 1000
`define APS_SCAN_CYC (`APS_SCAN_NS / `APS_CLK_NS)
`define APS_SCAN_W 8

// ****************************************************************
// Register word offsets (avs_address[7:2])
// ****************************************************************
`define APS_A_CTRL 6'h00
`define APS_A_CMD 6'h01
`define APS_A_FUNC 6'h02
`define APS_A_SPEED 6'h03
`define APS_A_OVR 6'h04
`define APS_A_TGT 6'h05
`define APS_A_INPW 6'h06
`define APS_A_PROXW 6'h07
`define APS_A_EXTD 6'h08
`define APS_A_ZLO 6'h09
`define APS_A_ZHI 6'h0a
`define APS_A_STAT 6'h0c
`define APS_A_WARN 6'h0d
`define APS_A_ALARM 6'h0e
`define APS_A_RESP 6'h0f
`define APS_A_CPOS 6'h10
`define APS_A_FPOS 6'h11

// ****************************************************************
// Control fields
// ****************************************************************
`define APS_C_SVON 0
`define APS_C_PAUSE 1
`define APS_C_ABORT 2
`define APS_C_ZONE 3
`define APS_C_ABS 4
`define APS_CTRL_W 5

// ****************************************************************
// Command and latch source codes
// ****************************************************************
`define APS_CMD_NOP 8'h00
`define APS_CMD_POS 8'h01
`define APS_CMD_EXPOS 8'h02
`define APS_SRC_INDEX 4'h2
`define APS_SRC_LATCH_INPUT_ONE 4'h3
`define APS_SRC_LATCH_INPUT_TWO 4'h4
`define APS_SRC_LATCH_INPUT_THREE 4'h5

// ****************************************************************
// Motion constants and reset values
// ****************************************************************
`define APS_OVR_MAX 16'h7fff
`define APS_OVR_DIV 48'h0000_0000_2710
`define APS_OVR_RST 16'h2710
`define APS_ACC_STEP 32'h0000_0100
`define APS_SYNC_W 70

`endif

// ===== rtl/aps_sync.v
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module aps_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_r;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/aps_top.v
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.vh"

module aps_top (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Servo drive status
  input wire drv_powered,
  input wire [15:0] drv_warning,
  input wire [15:0] drv_alarm,
  input wire drv_zone_support,
  input wire [31:0] feedback_position,
  // Latch pins
  input wire index_pulse,
  input wire latch_input_one,
  input wire latch_input_two,
  input wire latch_input_three,
  // Servo drive commands
  output reg servo_power_req,
  output reg [31:0] commanded_position
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_STOP = 2'd2;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire [`APS_SYNC_W-1:0] sync_q;
  wire pw_s;
  wire [15:0] warn_s;
  wire [15:0] alarm_s;
  wire zsup_s;
  wire [31:0] fpos_s;
  wire [3:0] lat_s;

  aps_sync #(.W(`APS_SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({drv_powered, drv_warning, drv_alarm, drv_zone_support, feedback_position,
        latch_input_three, latch_input_two, latch_input_one, index_pulse}),
    .q(sync_q)
  );

  assign {pw_s, warn_s, alarm_s, zsup_s, fpos_s, lat_s} = sync_q;

  // ****************************************************************
  // Scan divider
  // ****************************************************************
  reg [`APS_SCAN_W-1:0] scan_cnt_r;
  reg scan_tick_r;

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scan_cnt_r <= {`APS_SCAN_W{1'b0}};
      scan_tick_r <= 1'b0;
    end else if (scan_cnt_r == `APS_SCAN_CYC - 1) begin
      scan_cnt_r <= {`APS_SCAN_W{1'b0}};
      scan_tick_r <= 1'b1;
    end else begin
      scan_cnt_r <= scan_cnt_r + 1'b1;
      scan_tick_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Host setting registers
  // ****************************************************************
  reg [`APS_CTRL_W-1:0] ctrl_r;
  reg [7:0] cmd_r;
  reg [3:0] func_r;
  reg [31:0] speed_r;
  reg [15:0] ovr_r;
  reg [31:0] tgt_set_r;
  reg [31:0] inpw_r;
  reg [31:0] proxw_r;
  reg [31:0] extd_r;
  reg [31:0] zlo_r;
  reg [31:0] zhi_r;

  // Sequencer state
  reg [1:0] st_r;
  reg [7:0] act_r;
  reg [7:0] prev_cmd_r;
  reg [31:0] base_r;
  reg [31:0] tgt_r;
  reg [31:0] vel_r;
  reg latched_r;
  reg frz_r;
  reg servo_st_r;
  reg [15:0] warn_r;
  reg [15:0] alarm_r;
  reg exec_r;
  reg hold_r;
  reg err_r;
  reg xdone_r;
  reg den_r;
  reg inpos_r;
  reg prox_r;

  // Latch capture
  reg lat_d_r;
  reg lat_pend_r;
  reg [31:0] lat_pos_r;

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  wire [5:0] widx = avs_address[7:2];
  wire wr_go = avs_write & ~avs_waitrequest;
  wire [7:0] stat_w = {prox_r, inpos_r, den_r, xdone_r, err_r, hold_r, exec_r, servo_st_r};
  reg [31:0] rd_c;

  always @* begin
    case (widx)
      `APS_A_CTRL: rd_c = {27'h0, ctrl_r};
      `APS_A_CMD: rd_c = {24'h0, cmd_r};
      `APS_A_FUNC: rd_c = {28'h0, func_r};
      `APS_A_SPEED: rd_c = speed_r;
      `APS_A_OVR: rd_c = {16'h0, ovr_r};
      `APS_A_TGT: rd_c = tgt_set_r;
      `APS_A_INPW: rd_c = inpw_r;
      `APS_A_PROXW: rd_c = proxw_r;
      `APS_A_EXTD: rd_c = extd_r;
      `APS_A_ZLO: rd_c = zlo_r;
      `APS_A_ZHI: rd_c = zhi_r;
      `APS_A_STAT: rd_c = {24'h0, stat_w};
      `APS_A_WARN: rd_c = {16'h0, warn_r};
      `APS_A_ALARM: rd_c = {16'h0, alarm_r};
      `APS_A_RESP: rd_c = {24'h0, act_r};
      `APS_A_CPOS: rd_c = commanded_position;
      `APS_A_FPOS: rd_c = fpos_s;
      default: rd_c = 32'h0;
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      if ((avs_read | avs_write) & avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_c;
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= {`APS_CTRL_W{1'b0}};
      cmd_r <= `APS_CMD_NOP;
      func_r <= `APS_SRC_INDEX;
      speed_r <= 32'h0;
      ovr_r <= `APS_OVR_RST;
      tgt_set_r <= 32'h0;
      inpw_r <= 32'h0;
      proxw_r <= 32'h0;
      extd_r <= 32'h0;
      zlo_r <= 32'h0;
      zhi_r <= 32'h0;
    end else if (wr_go) begin
      case (widx)
        `APS_A_CTRL: ctrl_r <= avs_writedata[`APS_CTRL_W-1:0];
        `APS_A_CMD: cmd_r <= avs_writedata[7:0];
        `APS_A_FUNC: func_r <= avs_writedata[3:0];
        `APS_A_SPEED: speed_r <= avs_writedata;
        `APS_A_OVR: ovr_r <= avs_writedata[15:0];
        `APS_A_TGT: if (!lat_pend_r && !latched_r) tgt_set_r <= avs_writedata;
        `APS_A_INPW: inpw_r <= avs_writedata;
        `APS_A_PROXW: proxw_r <= avs_writedata;
        `APS_A_EXTD: extd_r <= avs_writedata;
        `APS_A_ZLO: zlo_r <= avs_writedata;
        `APS_A_ZHI: zhi_r <= avs_writedata;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // ****************************************************************
  // Latch source and capture
  // ****************************************************************
  reg lat_sel_c;

  always @* begin
    case (func_r)
      `APS_SRC_INDEX: lat_sel_c = lat_s[0];
      `APS_SRC_LATCH_INPUT_ONE: lat_sel_c = lat_s[1];
      `APS_SRC_LATCH_INPUT_TWO: lat_sel_c = lat_s[2];
      `APS_SRC_LATCH_INPUT_THREE: lat_sel_c = lat_s[3];
      default: lat_sel_c = 1'b0;
    endcase
  end

  wire zone_on = ctrl_r[`APS_C_ZONE] & zsup_s;
  wire in_zone = ($signed(fpos_s) >= $signed(zlo_r)) && ($signed(fpos_s) <= $signed(zhi_r));
  wire lat_ok = ~zone_on | in_zone;
  wire lat_evt = lat_sel_c & ~lat_d_r & lat_ok & (st_r == ST_RUN) &
                 (act_r == `APS_CMD_EXPOS) & ~latched_r & ~frz_r & (vel_r != 32'h0);

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lat_d_r <= 1'b0;
      lat_pend_r <= 1'b0;
      lat_pos_r <= 32'h0;
    end else begin
      lat_d_r <= lat_sel_c;
      if (lat_evt && !lat_pend_r) begin
        lat_pend_r <= 1'b1;
        lat_pos_r <= fpos_s;
      end else if (scan_tick_r) begin
        lat_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Motion profile
  // ****************************************************************
  function [31:0] aps_absdiff;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] d;
    begin
      d = a - b;
      aps_absdiff = d[31] ? (32'h0 - d) : d;
    end
  endfunction

  wire run = (st_r == ST_RUN);
  wire fault = ~servo_st_r | (alarm_r != 16'h0);
  wire [15:0] ovr_c = (ovr_r > `APS_OVR_MAX) ? `APS_OVR_MAX : ovr_r;
  wire [47:0] prod = speed_r * ovr_c;
  wire [47:0] vq = prod / `APS_OVR_DIV;
  wire [31:0] vmax = vq[31:0];
  wire [31:0] tgt_live = (latched_r | frz_r) ? tgt_r :
                         (ctrl_r[`APS_C_ABS] ? tgt_set_r : base_r + tgt_set_r);
  wire [31:0] rem = tgt_live - commanded_position;
  wire dir_neg = rem[31];
  wire [31:0] arem = dir_neg ? (32'h0 - rem) : rem;
  wire go = run & ~ctrl_r[`APS_C_PAUSE] & ~ctrl_r[`APS_C_ABORT];
  wire [32:0] vel_up = {1'b0, vel_r} + {1'b0, `APS_ACC_STEP};
  reg [31:0] vtry;
  reg [31:0] step;

  always @* begin
    if (go) begin
      vtry = (vel_up > {1'b0, vmax}) ? vmax : vel_up[31:0];
    end else begin
      vtry = (vel_r > `APS_ACC_STEP) ? (vel_r - `APS_ACC_STEP) : 32'h0;
    end
    step = (vtry > arem) ? arem : vtry;
  end

  wire [31:0] cpos_nxt = dir_neg ? (commanded_position - step) : (commanded_position + step);
  wire den_c = (arem == step);
  wire [31:0] pdiff = aps_absdiff(cpos_nxt, fpos_s);
  wire new_cmd = (cmd_r != prev_cmd_r);

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      act_r <= `APS_CMD_NOP;
      prev_cmd_r <= `APS_CMD_NOP;
      base_r <= 32'h0;
      tgt_r <= 32'h0;
      vel_r <= 32'h0;
      latched_r <= 1'b0;
      frz_r <= 1'b0;
      servo_st_r <= 1'b0;
      warn_r <= 16'h0;
      alarm_r <= 16'h0;
      exec_r <= 1'b0;
      hold_r <= 1'b0;
      err_r <= 1'b0;
      xdone_r <= 1'b0;
      den_r <= 1'b1;
      inpos_r <= 1'b0;
      prox_r <= 1'b0;
      servo_power_req <= 1'b0;
      commanded_position <= 32'h0;
    end else if (scan_tick_r) begin
      prev_cmd_r <= cmd_r;
      servo_power_req <= ctrl_r[`APS_C_SVON];
      servo_st_r <= pw_s;
      if (warn_s != 16'h0) begin
        warn_r <= warn_s;
      end
      if (alarm_s != 16'h0) begin
        alarm_r <= alarm_s;
      end
      if (new_cmd) begin
        err_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          vel_r <= 32'h0;
          exec_r <= 1'b0;
          hold_r <= 1'b0;
          den_r <= 1'b1;
          inpos_r <= (pdiff <= inpw_r);
          prox_r <= (proxw_r == 32'h0) ? 1'b1 : (pdiff < proxw_r);
          if (new_cmd && (cmd_r == `APS_CMD_POS || cmd_r == `APS_CMD_EXPOS)) begin
            if (fault) begin
              err_r <= 1'b1;
            end else begin
              st_r <= ST_RUN;
              act_r <= cmd_r;
              base_r <= commanded_position;
              latched_r <= 1'b0;
              frz_r <= 1'b0;
              xdone_r <= 1'b0;
              den_r <= 1'b0;
              inpos_r <= 1'b0;
            end
          end else if (new_cmd) begin
            xdone_r <= 1'b0;
          end
        end
        ST_RUN: begin
          if (cmd_r != act_r || fault) begin
            st_r <= ST_STOP;
            err_r <= fault & ~new_cmd;
            exec_r <= 1'b1;
            xdone_r <= 1'b0;
          end else begin
            vel_r <= step;
            commanded_position <= cpos_nxt;
            if (lat_pend_r && !latched_r && !frz_r) begin
              latched_r <= 1'b1;
              tgt_r <= dir_neg ? (lat_pos_r - extd_r) : (lat_pos_r + extd_r);
            end
            if (ctrl_r[`APS_C_ABORT] && step == 32'h0 && !frz_r) begin
              frz_r <= 1'b1;
              tgt_r <= commanded_position;
            end
            exec_r <= ctrl_r[`APS_C_ABORT] & (step != 32'h0);
            hold_r <= ctrl_r[`APS_C_PAUSE] & (step == 32'h0) & ~den_c;
            den_r <= den_c;
            inpos_r <= den_c & (pdiff <= inpw_r);
            prox_r <= (proxw_r == 32'h0) ? den_c : (pdiff < proxw_r);
            xdone_r <= (act_r == `APS_CMD_EXPOS) & latched_r & den_c;
          end
        end
        ST_STOP: begin
          vel_r <= step;
          commanded_position <= cpos_nxt;
          hold_r <= 1'b0;
          den_r <= 1'b0;
          inpos_r <= 1'b0;
          prox_r <= (proxw_r == 32'h0) ? 1'b0 : (pdiff < proxw_r);
          if (step == 32'h0) begin
            st_r <= ST_IDLE;
            act_r <= `APS_CMD_NOP;
            exec_r <= 1'b0;
            den_r <= 1'b1;
            frz_r <= 1'b0;
            latched_r <= 1'b0;
            base_r <= commanded_position;
            prev_cmd_r <= `APS_CMD_NOP;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== tb/aps_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.vh"

// ****************************************************************
// Bus and scan checks
// ****************************************************************
module aps_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Drive commands
  input wire logic servo_power_req,
  input wire logic [31:0] commanded_position
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  wire req = avs_read || avs_write;
  wire rdone = avs_read && !avs_waitrequest;

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  ans_within_a: assert property (req && avs_waitrequest |=> s_answer)
    else $error("bus answer missing");
  ans_cause_a: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("bus answer without request");
  ans_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (rdone && avs_address[7:2] > 6'h11 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  stat_upper_a: assert property (rdone && avs_address[7:2] == `APS_A_STAT |->
    avs_readdata[31:8] == 24'h0)
    else $error("status upper bits set");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  cpos_scan_a: assert property ($changed(commanded_position) |=> $stable(commanded_position)[*8])
    else $error("position updated twice in a scan");
  svreq_scan_a: assert property ($changed(servo_power_req) |=> $stable(servo_power_req)[*8])
    else $error("power request updated twice in a scan");
endmodule

`default_nettype wire

// ===== tb/aps_drive_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Servo drive with encoder
// ****************************************************************
module aps_drive_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // From block
  input wire logic servo_power_req,
  input wire logic [31:0] commanded_position,
  // To block
  output logic drv_powered,
  output logic [31:0] feedback_position
);
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drv_powered <= 1'b0;
      feedback_position <= 32'h0;
    end else begin
      drv_powered <= servo_power_req;
      feedback_position <= commanded_position;
    end
  end
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_defines.vh"

module tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [15:0] drv_warning = 16'h0;
  logic [15:0] drv_alarm = 16'h0;
  logic latch_input_one = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire drv_powered;
  wire [31:0] feedback_position;
  wire servo_power_req;
  wire [31:0] commanded_position;
  logic [31:0] q;
  logic [31:0] p;
  integer n_mismatch = 0;
  integer samples_checked = 0;
  integer i;

  always #5 sys_clk = ~sys_clk;

  aps_top aps_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drv_powered(drv_powered), .drv_warning(drv_warning),
    .drv_alarm(drv_alarm), .drv_zone_support(1'b0), .feedback_position(feedback_position),
    .index_pulse(1'b0), .latch_input_one(latch_input_one), .latch_input_two(1'b0),
    .latch_input_three(1'b0), .servo_power_req(servo_power_req),
    .commanded_position(commanded_position)
  );

  aps_drive_model aps_drive_model_inst (
    .sys_clk(sys_clk), .nrst(nrst), .servo_power_req(servo_power_req),
    .commanded_position(commanded_position), .drv_powered(drv_powered),
    .feedback_position(feedback_position)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask

  task bw;
    begin
      i = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && i < 50) begin
        @(posedge sys_clk);
        i = i + 1;
      end
      if (i == 50) begin
        n_mismatch = n_mismatch + 1;
        test_done;
      end
    end
  endtask

  task wr(input [5:0] w, input [31:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= {w, 2'b00};
      avs_writedata <= d;
      avs_write <= 1'b1;
      bw;
      avs_write <= 1'b0;
    end
  endtask

  task rc(input [5:0] w, input [31:0] m, input [31:0] e);
    begin
      @(posedge sys_clk);
      avs_address <= {w, 2'b00};
      avs_read <= 1'b1;
      bw;
      q = avs_readdata;
      avs_read <= 1'b0;
      chk(q & m, e);
    end
  endtask

  task scans(input integer n);
    begin
      repeat (n * 100) @(posedge sys_clk);
    end
  endtask

  task wpos(input [31:0] t);
    begin
      i = 0;
      while (commanded_position !== t && i < 9000) begin
        @(posedge sys_clk);
        i = i + 1;
      end
      chk(commanded_position, t);
      if (i == 9000) begin
        test_done;
      end
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rc(`APS_A_STAT, 32'hffffffff, 32'h20);
    rc(`APS_A_OVR, 32'hffffffff, 32'h2710);
    rc(`APS_A_FUNC, 32'hffffffff, 32'h2);
    rc(6'h0b, 32'hffffffff, 32'h0);
    wr(`APS_A_CTRL, 32'h11);
    wr(`APS_A_SPEED, 32'h3e8);
    wr(`APS_A_INPW, 32'ha);
    wr(`APS_A_TGT, 32'h4e20);
    scans(2);
    rc(`APS_A_STAT, 32'h1, 32'h1);
    wr(`APS_A_CMD, 32'h1);
    scans(2);
    rc(`APS_A_STAT, 32'h31, 32'h01);
    rc(`APS_A_RESP, 32'hff, 32'h1);
    scans(4);
    wr(`APS_A_CTRL, 32'h13);
    scans(8);
    rc(`APS_A_STAT, 32'h24, 32'h04);
    rc(`APS_A_CPOS, 32'hffffffff, 32'h1388);
    scans(2);
    rc(`APS_A_CPOS, 32'hffffffff, 32'h1388);
    wr(`APS_A_CTRL, 32'h11);
    wpos(32'h4e20);
    scans(2);
    rc(`APS_A_STAT, 32'hff, 32'he1);
    wr(`APS_A_CMD, 32'h0);
    wr(`APS_A_PROXW, 32'h100000);
    wr(`APS_A_TGT, 32'hea60);
    scans(2);
    wr(`APS_A_CMD, 32'h1);
    scans(8);
    rc(`APS_A_STAT, 32'ha0, 32'h80);
    wr(`APS_A_CMD, 32'h0);
    scans(1);
    rc(`APS_A_STAT, 32'h2, 32'h2);
    scans(10);
    rc(`APS_A_STAT, 32'h3, 32'h1);
    rc(`APS_A_RESP, 32'hffffffff, 32'h0);
    rc(`APS_A_WARN, 32'hffffffff, 32'h0);
    rc(`APS_A_ALARM, 32'hffffffff, 32'h0);
    wr(`APS_A_FUNC, `APS_SRC_LATCH_INPUT_ONE);
    wr(`APS_A_SPEED, 32'hc8);
    wr(`APS_A_EXTD, 32'h1f4);
    wr(`APS_A_TGT, 32'h100000);
    wr(`APS_A_CMD, 32'h2);
    scans(3);
    rc(`APS_A_RESP, 32'hff, 32'h2);
    p = commanded_position;
    i = 0;
    while (commanded_position === p && i < 300) begin
      @(posedge sys_clk);
      i = i + 1;
    end
    if (i == 300) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
    repeat (20) @(posedge sys_clk);
    p = feedback_position + 32'h1f4;
    latch_input_one <= 1'b1;
    repeat (4) @(posedge sys_clk);
    latch_input_one <= 1'b0;
    wr(`APS_A_TGT, 32'h0);
    wpos(p);
    scans(2);
    rc(`APS_A_STAT, 32'hff, 32'hf1);
    wr(`APS_A_CMD, 32'h0);
    scans(3);
    wr(`APS_A_CTRL, 32'h1);
    wr(`APS_A_SPEED, 32'h3e8);
    wr(`APS_A_TGT, 32'h100000);
    wr(`APS_A_CMD, 32'h1);
    scans(8);
    wr(`APS_A_CTRL, 32'h5);
    scans(1);
    rc(`APS_A_STAT, 32'h62, 32'h02);
    scans(6);
    rc(`APS_A_STAT, 32'h62, 32'h60);
    wr(`APS_A_CTRL, 32'h11);
    wr(`APS_A_CMD, 32'h0);
    scans(3);
    @(posedge sys_clk);
    drv_warning <= 16'h5;
    scans(1);
    drv_warning <= 16'h7;
    scans(1);
    drv_warning <= 16'h0;
    scans(2);
    rc(`APS_A_WARN, 32'hffffffff, 32'h7);
    drv_alarm <= 16'h9;
    scans(2);
    rc(`APS_A_ALARM, 32'hffffffff, 32'h9);
    wr(`APS_A_CMD, 32'h1);
    scans(2);
    rc(`APS_A_STAT, 32'h8, 32'h8);
    wr(`APS_A_CMD, 32'h0);
    scans(2);
    rc(`APS_A_STAT, 32'h8, 32'h0);
    test_done;
  end
endmodule

bind aps_top aps_checker aps_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .servo_power_req(servo_power_req), .commanded_position(commanded_position)
);

`default_nettype wire
